// File: hw/adc_threshold_trigger_ch23.sv
// Behaviour
// - combined trigger is the OR of all four channel trigger results
// - channel three trigger type lives in control bits 29..28, read/write
// - channel three: 00 never, 01 above threshold, 10 at or below
// - channel three 12-bit threshold lives in control bits 27..16
// - channel two trigger type lives in control bits 15..14, read/write
// - one control register enables and sets thresholds for channels two, three
// - channel two 12-bit threshold lives in control bits 11..0
`timescale 1ns/100ps
`default_nettype none
module adc_threshold_trigger_ch23 #(
  parameter int adc_w = 12
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire trig_pkg::apb_req_t apb_req,
  output var  trig_pkg::apb_rsp_t apb_rsp,
  // converter readings
  input  wire logic [adc_w-1:0]  analog_channel_two,
  input  wire logic [adc_w-1:0]  analog_channel_three,
  // channel 0/1 results from the companion logic
  input  wire logic [1:0]        ch01_trigger,
  // outputs
  output logic                   combined_trigger,
  output logic                   irq
);
  import trig_pkg::*;

  initial begin
    if (adc_w != 12) $error("adc_w must be 12 to fit the field layout");
  end

  // ==========================================================
  // threshold compare
  function automatic logic hit_f(input logic [1:0] typ, input logic [11:0] rd,
                                 input logic [11:0] thr);
    case (typ)
      trig_above: hit_f = rd > thr;
      trig_le:    hit_f = rd <= thr;
      default:    hit_f = 1'b0;
    endcase
  endfunction : hit_f

  state_t s_q;
  state_t s_d;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [1:0]  t2;
  logic [1:0]  t3;
  logic [11:0] th2;
  logic [11:0] th3;
  logic [3:0]  ev;
  // channel 0/1 levels one clock back, for their rising edges
  logic [1:0]  prev01_q;

  // ==========================================================
  // next state
  always_comb begin
    s_d    = s_q;
    wr     = apb_req.psel & apb_req.penable & apb_req.pwrite;
    rd     = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
    mapped = apb_req.paddr == ctrl_off || apb_req.paddr == stat_off ||
             apb_req.paddr == mask_off || apb_req.paddr == level_off;
    t3  = s_q.ctrl[ch3_type_lsb +: 2];
    th3 = s_q.ctrl[ch3_thr_lsb +: 12];
    t2  = s_q.ctrl[ch2_type_lsb +: 2];
    th2 = s_q.ctrl[ch2_thr_lsb +: 12];
    s_d.hit[1] = hit_f(t3, analog_channel_three, th3);
    s_d.hit[0] = hit_f(t2, analog_channel_two, th2);
    s_d.comb = |{s_q.hit, ch01_trigger};
    // rising edges of each channel result feed sticky status
    ev = {s_d.hit, ch01_trigger} & ~{s_q.hit, prev01_q};
    s_d.err = 1'b0;
    if (wr && apb_req.paddr == stat_off) begin
      s_d.stat = s_q.stat & ~apb_req.pwdata[stat_w-1:0];
    end
    // set beats clear
    s_d.stat = s_d.stat | ev;
    if (wr) begin
      case (apb_req.paddr)
        ctrl_off: s_d.ctrl = apb_req.pwdata & ctrl_rw_mask;
        mask_off: s_d.mask = apb_req.pwdata[stat_w-1:0];
        default:  s_d.err  = ~mapped;
      endcase
    end
    if (rd) begin
      case (apb_req.paddr)
        ctrl_off:  s_d.rdata = s_q.ctrl;
        stat_off:  s_d.rdata = {28'h0000000, s_q.stat};
        mask_off:  s_d.rdata = {28'h0000000, s_q.mask};
        level_off: s_d.rdata = {28'h0000000, s_q.hit, ch01_trigger};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.err   = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '{ctrl: ctrl_reset, default: '0};
      prev01_q <= 2'b00;
    end else begin
      s_q      <= s_d;
      prev01_q <= ch01_trigger;
    end
  end

  // zero-wait slave: data is combinational off the current state
  always_comb begin
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped;
    case (apb_req.paddr)
      ctrl_off:  apb_rsp.prdata = s_q.ctrl;
      stat_off:  apb_rsp.prdata = {28'h0000000, s_q.stat};
      mask_off:  apb_rsp.prdata = {28'h0000000, s_q.mask};
      level_off: apb_rsp.prdata = {28'h0000000, s_q.hit, prev01_q};
      default:   apb_rsp.prdata = 32'h0000_0000;
    endcase
  end

  assign combined_trigger = s_q.comb;
  assign irq              = |(s_q.stat & s_q.mask);
endmodule : adc_threshold_trigger_ch23
`default_nettype wire

// File: inc/trig_pkg.sv
`default_nettype none
package trig_pkg;
  // ==========================================================
  // register map
  localparam logic [11:0] ctrl_off      = 12'h000;
  localparam logic [11:0] stat_off      = 12'h004;
  localparam logic [11:0] mask_off      = 12'h008;
  localparam logic [11:0] level_off     = 12'h00c;
  localparam logic [31:0] ctrl_reset    = 32'h0000_0000;
  localparam logic [31:0] ctrl_rw_mask  = 32'h3fff_cfff;
  // ==========================================================
  // field positions
  localparam int ch3_type_lsb = 28;
  localparam int ch3_thr_lsb  = 16;
  localparam int ch2_type_lsb = 14;
  localparam int ch2_thr_lsb  = 0;
  localparam int stat_w       = 4;
  // ==========================================================
  // trigger type codes
  typedef enum logic [1:0] {
    trig_never = 2'b00,
    trig_above = 2'b01,
    trig_le    = 2'b10
  } trig_type_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic [1:0]  hit;
    logic        comb;
    logic [31:0] rdata;
    logic        err;
  } state_t;
endpackage : trig_pkg
`default_nettype wire

// File: sim/trig_checker.sv
`timescale 1ns/100ps
`default_nettype none
module trig_checker (
  // watched ports
  input wire logic              pclk,
  input wire logic              presetn,
  input wire trig_pkg::apb_req_t apb_req,
  input wire trig_pkg::apb_rsp_t apb_rsp,
  input wire logic [11:0]       analog_channel_two,
  input wire logic [11:0]       analog_channel_three,
  input wire logic [1:0]        ch01_trigger,
  input wire logic              combined_trigger
);
  import trig_pkg::*;
  logic [31:0] c_q;
  wire [1:0] t3 = c_q[29:28];
  wire [1:0] t2 = c_q[15:14];
  wire wr0 = apb_req.psel & apb_req.penable & apb_req.pwrite & (apb_req.paddr == ctrl_off);
  // shadow control word; reserved bits never stick
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) c_q <= '0;
    else if (wr0) c_q <= apb_req.pwdata & 32'h3fff_cfff;
  sequence rd0;
    apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_req.paddr == ctrl_off;
  endsequence
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ch01_or: assert property ($past(|ch01_trigger) |-> combined_trigger)
    else $error("or lost");
  a_ch3_type: assert property (rd0 |-> apb_rsp.prdata[29:28] == t3)
    else $error("ch3 type");
  a_ch3_thr: assert property (rd0 |-> apb_rsp.prdata[27:16] == c_q[27:16])
    else $error("ch3 thr");
  a_ch2_type: assert property (rd0 |-> apb_rsp.prdata[15:14] == t2)
    else $error("ch2 type");
  a_rsvd_zero: assert property (rd0 |-> (apb_rsp.prdata & 32'hc000_3000) == 0)
    else $error("reserved");
  a_ch2_thr: assert property (rd0 |-> apb_rsp.prdata[11:0] == c_q[11:0])
    else $error("ch2 thr");
  a_ch3_fire: assert property (t3 == 2'b01 && analog_channel_three > c_q[27:16] ||
    t3 == 2'b10 && analog_channel_three <= c_q[27:16] |-> ##2 combined_trigger) else $error("ch3");
  a_ch2_fire: assert property (t2 == 2'b01 && analog_channel_two > c_q[11:0] ||
    t2 == 2'b10 && analog_channel_two <= c_q[11:0] |-> ##2 combined_trigger) else $error("ch2");
  a_never_quiet: assert property ((t3 == 0 && t2 == 3 && ch01_trigger == 0)[*3]
    |-> !combined_trigger) else $error("quiet");
endmodule : trig_checker
`default_nettype wire

// File: sim/adc_model.sv
`timescale 1ns/100ps
`default_nettype none
module adc_model (
  // clock and request
  input  wire logic        pclk,
  input  wire logic [23:0] want,
  // readings
  output logic      [11:0] ch2,
  output logic      [11:0] ch3
);
  // a finished conversion shows one clock after it is asked for
  always_ff @(posedge pclk) {ch3, ch2} <= want;
endmodule : adc_model
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import trig_pkg::*;
  logic pclk = 0, presetn = 0, cmb, irq;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic [23:0] want = '0;
  logic [11:0] ch2, ch3;
  logic [1:0] c01 = '0;
  logic [31:0] c, q;
  logic        e;
  int seed = 98, n_errors = 0, samples_checked = 0;
  always #5 pclk = ~pclk;
  adc_model u_adc_model (.pclk(pclk), .want(want), .ch2(ch2), .ch3(ch3));
  adc_threshold_trigger_ch23 u_adc_threshold_trigger_ch23 (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .analog_channel_two(ch2), .analog_channel_three(ch3),
    .ch01_trigger(c01), .combined_trigger(cmb), .irq(irq));
  function automatic int hit(int t, int r, int h);
    return t == 1 ? r > h : t == 2 ? r <= h : 0;
  endfunction : hit
  task automatic chk(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
  endtask : xfer
  task close_out;
    $display("compared %0d mismatched %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1, mask_off, 32'hf);
    repeat (40) begin
      c = $random(seed);
      xfer(1, ctrl_off, c);
      xfer(0, ctrl_off, 0);
      chk(q, c & 32'h3fff_cfff);
      want <= {c[27:16] + 12'($random(seed) % 2), c[11:0] + 12'($random(seed) % 2)};
      c01 <= 2'($random(seed));
      repeat (4) @(posedge pclk);
      chk(cmb, |c01 | hit(c[29:28], want[23:12], c[27:16]) | hit(c[15:14], want[11:0], c[11:0]));
    end
    $display("trigger sweep done");
    c01 <= 2'b00;
    xfer(1, ctrl_off, 32'h0000_c000);
    xfer(1, stat_off, 32'hf);
    xfer(0, 12'h010, 32'h0);
    chk(q, 0);
    chk(e, 1);
    chk(cmb, 0);
    chk(irq, 0);
    c01 <= 2'b10;
    repeat (3) @(posedge pclk);
    chk(cmb, 1);
    chk(irq, 1);
    xfer(1, mask_off, 32'h0);
    chk(irq, 0);
    $display("interrupt test done");
    close_out();
  end
endmodule : tb
bind adc_threshold_trigger_ch23 trig_checker u_trig_checker (.*);
`default_nettype wire
